/* gcr_map.vh */
// register, coil and timing constants for the gateway coil and register map
`ifndef GCR_MAP_VH
`define GCR_MAP_VH
`define GCR_SLOT_COUNT 50
`define GCR_SLOT_COIL_BASE 16'h07D0
`define GCR_SLOT_COIL_LAST 16'h0897
`define GCR_COIL_ALIVE 2'h0
`define GCR_COIL_ALARM 2'h1
`define GCR_COIL_PENDING 2'h2
`define GCR_COIL_PULL 2'h3
`define GCR_GW_COIL_RESET 16'h0001
`define GCR_GW_COIL_REFORM 16'h0002
`define GCR_REG_VERSION 16'h0000
`define GCR_REG_IDENT_HIGH 16'h0001
`define GCR_REG_IDENT_LOW 16'h0002
`define GCR_REG_DEV_COUNT 16'h0003
`define GCR_REG_OP_CHANNEL 16'h0004
`define GCR_REG_SPEED 16'h0005
`define GCR_REG_FRAMING 16'h0006
`define GCR_REG_STATION 16'h0007
`define GCR_REG_MASK_HIGH 16'h0008
`define GCR_REG_MASK_LOW 16'h0009
`define GCR_REG_SECONDS_HIGH 16'h000A
`define GCR_REG_SECONDS_LOW 16'h000B
`define GCR_SPEED_RESET 16'h0003
`define GCR_SPEED_MAX 16'h0006
`define GCR_FRAMING_RESET 16'h0000
`define GCR_FRAMING_MAX 16'h0006
`define GCR_STATION_RESET 16'h005F
`define GCR_STATION_MIN 16'h0001
`define GCR_STATION_MAX 16'h00F7
`define GCR_MASK_RESET 32'hFFFFFFFF
`define GCR_DEV_COUNT_MAX 16'h0032
`define GCR_CHANNEL_MAX 16'h0019
`define GCR_CLK_HZ 20000000
`define GCR_SECOND_NS 1000000000
`define GCR_CLK_NS 50
`define GCR_SECOND_CYCLES (`GCR_SECOND_NS / `GCR_CLK_NS)
`endif

/* gcr_coil_register_map.v */
// coil and holding register map of the wireless sensor gateway
//
// Contract
// - each of 50 slots has four coils at 2000 plus four times slot
// - link-alive coil reads 1 while synchronized, 0 after silence limit
// - link-alive coil reads 0 when no devices are registered
// - alarm coil reads 1 in exception state, 0 otherwise
// - config-pending coil reads 1 while any local copy differs from remote
// - writing 1 to config-pending pushes slot configuration to remote device
// - writing 0 to config-pending is ignored
// - config-pending clears itself once remote confirms applied changes
// - remote-pull coil reads 0; writing 1 clears slot and pulls config
// - firmware version is read-only at register 0
// - unique identifier read-only at registers 1 and 2, high then low
// - registered device count read-only at 3, limited to 0..50
// - operating channel read-only at 4, limited to 0..25
// - serial speed at 5, codes 0..6, default code 3
// - framing mode at 6, codes 0..6, default 0
// - station address at 7, values 1..247, default 95
// - channel mask at 8 and 9, 32 bits, reset all ones
// - seconds counter at 10 and 11, writable, counts on from written value
// - gateway reset coil 1 resets device and status, reads 0
// - network-reform coil 2 re-forms network, reads 0
`include "gcr_map.vh"
`default_nettype none
module gcr_coil_register_map #(
	parameter [31:0] second_cycles = `GCR_SECOND_CYCLES,
	parameter [15:0] firmware_version = 16'h0100,
	parameter [31:0] unique_ident = 32'h00000001
) (
	input wire core_clk,
	input wire rst_n,
	input wire reg_rd,
	input wire reg_wr,
	input wire [15:0] reg_addr,
	input wire [15:0] reg_wdata,
	output reg [15:0] reg_rdata,
	output reg reg_ack,
	output reg reg_err,
	input wire coil_rd,
	input wire coil_wr,
	input wire [15:0] coil_addr,
	input wire coil_wdata,
	output reg coil_rdata,
	output reg coil_ack,
	output reg coil_err,
	input wire [49:0] slot_alive,
	input wire [49:0] slot_alarm,
	input wire [49:0] slot_local_edit,
	input wire [49:0] slot_confirm,
	input wire [15:0] registered_device_count,
	input wire [15:0] operating_channel,
	output reg [49:0] push_request,
	output reg [49:0] pull_request,
	output reg gateway_reset_pulse,
	output reg network_reform_pulse,
	output reg [15:0] active_serial_speed,
	output reg [15:0] active_framing_mode,
	output reg [15:0] active_station_address,
	output wire [31:0] channel_permit_mask,
	output wire [31:0] seconds_count
);
	reg [15:0] serial_speed_select;
	reg [15:0] framing_mode_select;
	reg [15:0] bus_station_address;
	reg [15:0] channel_permit_mask_high;
	reg [15:0] channel_permit_mask_low;
	reg [31:0] seconds;
	reg [31:0] tick_count;
	reg [49:0] pending;
	reg boot_load;
	wire second_tick;
	wire [15:0] coil_rel;
	wire in_slots;
	wire [5:0] device_slot_index;
	wire [1:0] coil_sel;
	wire [15:0] dev_count_clip;
	wire [15:0] channel_clip;
	reg [49:0] next_pending;
	reg [15:0] next_rdata;
	reg next_err;
	reg next_coil;
	reg next_coil_err;
	localparam [31:0] mask_reset = `GCR_MASK_RESET;

	assign second_tick = (tick_count == second_cycles - 32'h00000001);
	assign coil_rel = coil_addr - `GCR_SLOT_COIL_BASE;
	assign in_slots = (coil_addr >= `GCR_SLOT_COIL_BASE) && (coil_addr <= `GCR_SLOT_COIL_LAST);
	assign device_slot_index = coil_rel[7:2];
	assign coil_sel = coil_rel[1:0];
	assign dev_count_clip = (registered_device_count > `GCR_DEV_COUNT_MAX) ?
		`GCR_DEV_COUNT_MAX : registered_device_count;
	assign channel_clip = (operating_channel > `GCR_CHANNEL_MAX) ?
		`GCR_CHANNEL_MAX : operating_channel;
	assign channel_permit_mask = {channel_permit_mask_high, channel_permit_mask_low};
	assign seconds_count = seconds;

	// register read decode
	always @* begin
		next_rdata = 16'h0000;
		next_err = 1'b0;
		case (reg_addr)
			`GCR_REG_VERSION: next_rdata = firmware_version;
			`GCR_REG_IDENT_HIGH: next_rdata = unique_ident[31:16];
			`GCR_REG_IDENT_LOW: next_rdata = unique_ident[15:0];
			`GCR_REG_DEV_COUNT: next_rdata = dev_count_clip;
			`GCR_REG_OP_CHANNEL: next_rdata = channel_clip;
			`GCR_REG_SPEED: next_rdata = serial_speed_select;
			`GCR_REG_FRAMING: next_rdata = framing_mode_select;
			`GCR_REG_STATION: next_rdata = bus_station_address;
			`GCR_REG_MASK_HIGH: next_rdata = channel_permit_mask_high;
			`GCR_REG_MASK_LOW: next_rdata = channel_permit_mask_low;
			`GCR_REG_SECONDS_HIGH: next_rdata = seconds[31:16];
			`GCR_REG_SECONDS_LOW: next_rdata = seconds[15:0];
			default: next_err = 1'b1;
		endcase
	end

	// coil read decode
	always @* begin
		next_coil = 1'b0;
		next_coil_err = 1'b0;
		if (in_slots) begin
			case (coil_sel)
				`GCR_COIL_ALIVE: next_coil = slot_alive[device_slot_index] &&
					(registered_device_count != 16'h0000);
				`GCR_COIL_ALARM: next_coil = slot_alarm[device_slot_index];
				`GCR_COIL_PENDING: next_coil = pending[device_slot_index];
				default: next_coil = 1'b0;
			endcase
		end else if (coil_addr == `GCR_GW_COIL_RESET || coil_addr == `GCR_GW_COIL_REFORM) begin
			next_coil = 1'b0;
		end else begin
			next_coil_err = 1'b1;
		end
	end

	// pending flags: local edits and push requests set, confirmations clear, set wins over confirmation; a pull write clears and wins over all
	always @* begin
		next_pending = pending & ~slot_confirm;
		next_pending = next_pending | slot_local_edit;
		if (coil_wr && in_slots && coil_sel == `GCR_COIL_PENDING && coil_wdata) begin
			next_pending[device_slot_index] = 1'b1;
		end
		if (coil_wr && in_slots && coil_sel == `GCR_COIL_PULL && coil_wdata) begin
			next_pending[device_slot_index] = 1'b0;
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_speed_select <= `GCR_SPEED_RESET;
			framing_mode_select <= `GCR_FRAMING_RESET;
			bus_station_address <= `GCR_STATION_RESET;
			channel_permit_mask_high <= mask_reset[31:16];
			channel_permit_mask_low <= mask_reset[15:0];
			seconds <= 32'h00000000;
			tick_count <= 32'h00000000;
			pending <= 50'h0;
			push_request <= 50'h0;
			pull_request <= 50'h0;
			gateway_reset_pulse <= 1'b0;
			network_reform_pulse <= 1'b0;
			active_serial_speed <= `GCR_SPEED_RESET;
			active_framing_mode <= `GCR_FRAMING_RESET;
			active_station_address <= `GCR_STATION_RESET;
			boot_load <= 1'b1;
			reg_rdata <= 16'h0000;
			reg_ack <= 1'b0;
			reg_err <= 1'b0;
			coil_rdata <= 1'b0;
			coil_ack <= 1'b0;
			coil_err <= 1'b0;
		end else begin
			boot_load <= 1'b0;
			if (boot_load) begin
				active_serial_speed <= serial_speed_select;
				active_framing_mode <= framing_mode_select;
				active_station_address <= bus_station_address;
			end
			// the gateway reset coil applies the stored link settings
			if (coil_wr && coil_wdata && coil_addr == `GCR_GW_COIL_RESET) begin
				active_serial_speed <= serial_speed_select;
				active_framing_mode <= framing_mode_select;
				active_station_address <= bus_station_address;
			end
			tick_count <= second_tick ? 32'h00000000 : tick_count + 32'h00000001;
			if (second_tick) begin
				seconds <= seconds + 32'h00000001;
			end
			reg_ack <= reg_rd || reg_wr;
			reg_err <= (reg_rd || reg_wr) && next_err;
			if (reg_rd) begin
				reg_rdata <= next_rdata;
			end
			if (reg_wr) begin
				case (reg_addr)
					`GCR_REG_SPEED: if (reg_wdata <= `GCR_SPEED_MAX)
						serial_speed_select <= reg_wdata;
					`GCR_REG_FRAMING: if (reg_wdata <= `GCR_FRAMING_MAX)
						framing_mode_select <= reg_wdata;
					`GCR_REG_STATION: if (reg_wdata >= `GCR_STATION_MIN &&
						reg_wdata <= `GCR_STATION_MAX)
						bus_station_address <= reg_wdata;
					`GCR_REG_MASK_HIGH: channel_permit_mask_high <= reg_wdata;
					`GCR_REG_MASK_LOW: channel_permit_mask_low <= reg_wdata;
					`GCR_REG_SECONDS_HIGH: seconds[31:16] <= reg_wdata;
					`GCR_REG_SECONDS_LOW: seconds[15:0] <= reg_wdata;
					default: ;
				endcase
			end
			coil_ack <= coil_rd || coil_wr;
			coil_err <= (coil_rd || coil_wr) && next_coil_err;
			if (coil_rd) begin
				coil_rdata <= next_coil;
			end
			pending <= next_pending;
			push_request <= 50'h0;
			pull_request <= 50'h0;
			gateway_reset_pulse <= 1'b0;
			network_reform_pulse <= 1'b0;
			if (coil_wr && coil_wdata) begin
				if (in_slots && coil_sel == `GCR_COIL_PENDING)
					push_request[device_slot_index] <= 1'b1;
				if (in_slots && coil_sel == `GCR_COIL_PULL)
					pull_request[device_slot_index] <= 1'b1;
				if (coil_addr == `GCR_GW_COIL_RESET)
					gateway_reset_pulse <= 1'b1;
				if (coil_addr == `GCR_GW_COIL_REFORM)
					network_reform_pulse <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* gcr_map_asserts.sv */
// protocol checker for the gateway coil and register map
`default_nettype none
module gcr_map_asserts (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_ack,
	input wire logic coil_rd,
	input wire logic coil_wr,
	input wire logic [15:0] coil_addr,
	input wire logic coil_wdata,
	input wire logic coil_rdata,
	input wire logic coil_ack,
	input wire logic [15:0] registered_device_count,
	input wire logic [49:0] push_request,
	input wire logic [49:0] pull_request,
	input wire logic gateway_reset_pulse,
	input wire logic network_reform_pulse,
	input wire logic [31:0] seconds_count
);
	wire hit = coil_addr >= 16'h07D0 && coil_addr <= 16'h0897;
	wire [15:0] slot = (coil_addr - 16'h07D0) >> 2;
	wire set1 = coil_wr && coil_wdata;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	reg_answer_a: assert property ((reg_rd || reg_wr) |=> reg_ack) else $error("no reg ack");
	coil_answer_a: assert property ((coil_rd || coil_wr) |=> coil_ack) else $error("no coil ack");
	push_slot_a: assert property (set1 && hit && coil_addr[1:0] == 2'h2 |=>
		push_request[$past(slot)]) else $error("no push");
	push_cause_a: assert property (|push_request |-> $past(set1)) else $error("stray push");
	pull_slot_a: assert property (set1 && hit && coil_addr[1:0] == 2'h3 |=>
		pull_request[$past(slot)]) else $error("no pull");
	pull_zero_a: assert property (coil_rd && hit && coil_addr[1:0] == 2'h3 |=> !coil_rdata)
		else $error("pull coil not 0");
	alive_none_a: assert property (coil_rd && hit && coil_addr[1:0] == 2'h0 &&
		registered_device_count == 16'h0 |=> !coil_rdata) else $error("alive with none");
	gw_coil_zero_a: assert property (coil_rd && (coil_addr == 16'h0001 || coil_addr == 16'h0002)
		|=> !coil_rdata) else $error("gateway coil not 0");
	reset_pulse_a: assert property (set1 && coil_addr == 16'h0001 |=> gateway_reset_pulse)
		else $error("no reset pulse");
	reform_pulse_a: assert property (set1 && coil_addr == 16'h0002 |=> network_reform_pulse)
		else $error("no reform pulse");
	count_clip_a: assert property (reg_rd && reg_addr == 16'h0003 |=> reg_rdata <= 16'h0032)
		else $error("count above 50");
	seconds_step_a: assert property ($changed(seconds_count) && !$past(reg_wr) |->
		seconds_count == $past(seconds_count) + 32'h1) else $error("bad second step");
	cover property (|push_request);
	cover property (|pull_request);
	cover property (gateway_reset_pulse);
endmodule
bind gcr_coil_register_map gcr_map_asserts i_gcr_map_asserts (.*);
`default_nettype wire

/* gcr_master_model.sv */
// serial bus master model issuing register and coil requests
`default_nettype none
module gcr_master_model (
	input wire logic core_clk,
	input wire logic reg_ack,
	input wire logic reg_err,
	input wire logic [15:0] reg_rdata,
	input wire logic coil_ack,
	input wire logic coil_err,
	input wire logic coil_rdata,
	output logic reg_rd,
	output logic reg_wr,
	output logic [15:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic coil_rd,
	output logic coil_wr,
	output logic [15:0] coil_addr,
	output logic coil_wdata
);
	initial begin
		{reg_rd, reg_wr, coil_rd, coil_wr} = 4'h0;
		{reg_addr, reg_wdata, coil_addr, coil_wdata} = 49'h0;
	end
	task automatic op(input bit c, input bit w, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic e);
		int n;
		@(negedge core_clk);
		if (c) {coil_rd, coil_wr, coil_addr, coil_wdata} = {!w, w, a, d[0]};
		else {reg_rd, reg_wr, reg_addr, reg_wdata} = {!w, w, a, d};
		@(negedge core_clk);
		{reg_rd, reg_wr, coil_rd, coil_wr} = 4'h0;
		for (n = 0; n < 4 && !(c ? coil_ack : reg_ack); n++) @(negedge core_clk);
		q = c ? {15'h0, coil_rdata} : reg_rdata;
		e = c ? coil_err : reg_err;
		{reg_addr, reg_wdata, coil_addr, coil_wdata} = ~{reg_addr, reg_wdata, coil_addr, coil_wdata};
		if (n == 4) begin
			gcr_coil_register_map_tb.n_fail++;
			gcr_coil_register_map_tb.tally_and_finish();
		end
	endtask
endmodule
`default_nettype wire

/* gcr_coil_register_map_tb.sv */
// self-checking bench for the gateway coil and register map
`default_nettype none
module gcr_coil_register_map_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] VER = 16'h0123; // arbitrary value
	localparam logic [31:0] ID = 32'h1234ABCD; // arbitrary value
	logic core_clk = 1'b0, rst_n = 1'b0, reg_rd, reg_wr, reg_ack, reg_err, e;
	logic coil_rd, coil_wr, coil_wdata, coil_rdata, coil_ack, coil_err, gateway_reset_pulse;
	logic network_reform_pulse;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, coil_addr, q, b, registered_device_count;
	logic [15:0] operating_channel, active_serial_speed, active_framing_mode;
	logic [15:0] active_station_address;
	logic [49:0] slot_alive, slot_alarm, slot_local_edit, slot_confirm, push_request, pull_request;
	logic [31:0] channel_permit_mask, seconds_count;
	int seed = 32'h65E2, n_fail = 0, checked = 0, i, exp[12];
	int wa[11] = '{0, 3, 4, 5, 5, 6, 6, 7, 7, 7, 9};
	int wd[11] = '{1, 9, 9, 4, 7, 6, 7, 0, 248, 247, 17};
	int sl[3] = '{0, 49, 0};
	gcr_coil_register_map #(.second_cycles(32'hA), .firmware_version(VER), .unique_ident(ID))
		i_gcr_coil_register_map (.*);
	gcr_master_model i_gcr_master_model (.*);
	initial forever #25 core_clk = ~core_clk;
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want) begin
			n_fail++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic tally_and_finish();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic rr(input logic [15:0] a, input logic [15:0] want);
		i_gcr_master_model.op(0, 0, a, 16'h0, q, e);
		check(q, want);
	endtask
	task automatic cr(input logic [15:0] a, input logic want);
		i_gcr_master_model.op(1, 0, a, 16'h0, q, e);
		check(q, want);
	endtask
	task automatic cw(input logic [15:0] a, input bit d);
		i_gcr_master_model.op(1, 1, a, {15'h0, d}, q, e);
	endtask
	task automatic rw(input int a, input int d);
		i_gcr_master_model.op(0, 1, 16'(a), 16'(d), q, e);
		if ((a == 5 || a == 6) && d <= 6 || a == 7 && d > 0 && d < 248 || a > 7) exp[a] = d;
	endtask
	task automatic tick(input int s, input bit edit);
		@(negedge core_clk);
		if (edit) slot_local_edit[s] = 1'b1;
		else slot_confirm[s] = 1'b1;
		@(negedge core_clk);
		{slot_local_edit, slot_confirm} = 100'h0;
	endtask
	initial begin
		{slot_local_edit, slot_confirm} = 100'h0;
		slot_alive = 50'({$random(seed), $random(seed)});
		slot_alarm = 50'({$random(seed), $random(seed)});
		{registered_device_count, operating_channel} = {$random(seed)} & 32'h003F001F;
		repeat (8) @(posedge core_clk);
		@(negedge core_clk) rst_n = 1'b1;
		exp = '{VER, ID[31:16], ID[15:0], registered_device_count > 50 ? 50 : registered_device_count,
			operating_channel > 25 ? 25 : operating_channel, 3, 0, 95, 16'hFFFF, 16'hFFFF, 0, 0};
		for (i = 0; i < 10; i++) rr(16'(i), 16'(exp[i]));
		foreach (wa[k]) begin
			rw(wa[k], wd[k]);
			rr(16'(wa[k]), 16'(exp[wa[k]]));
		end
		check(channel_permit_mask, {16'(exp[8]), 16'(exp[9])});
		check(active_serial_speed, 3);
		i_gcr_master_model.op(1, 0, 16'h0898, 16'h0, q, e);
		check(e, 1);
		i_gcr_master_model.op(0, 0, 16'h000C, 16'h0, q, e);
		check(e, 1);
		rw(10, 65535);
		rw(11, 65535);
		for (i = 0; i < 30 && seconds_count !== 0; i++) @(negedge core_clk);
		check(seconds_count, 0);
		if (i == 30) tally_and_finish();
		foreach (sl[k]) begin
			if (k == 2) {registered_device_count, slot_alive} = {16'h0, {50{1'b1}}};
			b = 16'h07D0 + 16'(4 * sl[k]);
			cr(b, registered_device_count != 0 && slot_alive[sl[k]]);
			cw(b, 1);
			cr(b, registered_device_count != 0 && slot_alive[sl[k]]);
			cr(b + 1, slot_alarm[sl[k]]);
			cr(b + 3, 0);
			cw(b + 2, 0);
			cr(b + 2, 0);
			cw(b + 2, 1);
			cr(b + 2, 1);
			tick(sl[k], 0);
			cr(b + 2, 0);
			tick(sl[k], 1);
			cr(b + 2, 1);
			cw(b + 3, 1);
			cr(b + 2, 0);
		end
		cr(1, 0);
		cr(2, 0);
		check(active_serial_speed, 3);
		cw(1, 1);
		check(active_serial_speed, 16'(exp[5]));
		check(active_framing_mode, 16'(exp[6]));
		check(active_station_address, 16'(exp[7]));
		cw(2, 1);
		@(negedge core_clk) rst_n = 1'b0;
		@(negedge core_clk) rst_n = 1'b1;
		check(channel_permit_mask, 32'hFFFFFFFF);
		check(active_serial_speed, 3);
		tally_and_finish();
	end
endmodule
`default_nettype wire
